// >>> hdl/cesr_block.v
// CAN error status, error counters and receive buffer count logic.
`timescale 1ns/1ps
`default_nettype none
`include "cesr_consts.vh"

module cesr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            empty;
  wire            full;
  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                     (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  always @* begin
    out_data = mem[rd_ptr[AW-1:0]];
  end
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module cesr_block (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] sfr_addr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  output reg  [7:0]  sfr_rdata,
  input  wire        init_request,
  input  wire        sleep_request,
  output reg         init_set_by_reset,
  input  wire        rx_pin,
  input  wire        proto_busy,
  input  wire        internal_busy,
  input  wire        sleep_mode,
  input  wire        bit_tick,
  input  wire        frame_ok,
  input  wire        frame_start,
  input  wire        rx_err_inc1,
  input  wire        rx_err_inc8,
  input  wire        rx_err_dec,
  input  wire        tx_err_inc8,
  input  wire        tx_err_dec,
  input  wire        tx_fetch_fail,
  input  wire        rx_store_busy,
  input  wire        id_cmp_busy,
  input  wire [7:0]  rx_byte,
  input  wire        rx_byte_valid,
  output wire        rx_byte_ready,
  output wire [7:0]  store_data,
  output wire        store_valid,
  input  wire        store_ready,
  output reg         rx_flags_block,
  output reg         msg_discard,
  output reg         tx_request_hold,
  output reg         status_irq,
  output wire        error_irq,
  output wire [4:0]  rx_buffer_count
);
  reg       rx_meta;
  reg       rx_sync;
  reg [8:0] tx_cnt;
  reg [7:0] rx_cnt;
  reg       bus_off_flag;
  reg       rx_err_warn_flag;
  reg       tx_err_warn_flag;
  reg       config_mode_ack;
  reg       valid_flag;
  reg       wake_flag;
  reg       over_flag;
  reg       over_pulse;
  reg [7:0] cfg;
  reg [3:0] idle_bits;
  reg [7:0] idle_runs;
  reg [2:0] frame_bits;
  reg       store_late;
  reg       cmp_late;
  wire      wr_status;
  wire      hard_reset;
  wire      over_event;
  wire      in_frame_head;
  wire      next_bus_off;
  wire      next_rx_warn;
  wire      next_tx_warn;

  function [4:0] cesr_norm_count;
    input [4:0] raw;
    begin
      if (raw[4] && (raw[3:0] != 4'h0)) begin
        cesr_norm_count = `CESR_COUNT_MAX;
      end else begin
        cesr_norm_count = raw;
      end
    end
  endfunction

  // Warning compare shared by both counters and by the interrupt term.
  function cesr_at_warn;
    input [8:0] count;
    begin
      cesr_at_warn = (count >= `CESR_WARN_LEVEL);
    end
  endfunction

  assign wr_status  = sfr_wr && (sfr_addr == `CESR_ADDR_ERR_STATUS);
  assign hard_reset = sfr_wr && (sfr_addr == `CESR_ADDR_RX_BUF_CFG) &&
                      sfr_wdata[`CESR_BIT_HARD_RESET] && bus_off_flag;
  assign in_frame_head = (frame_bits < `CESR_SIX_BITS);
  // A hard reset drops bus-off at once, so the granted mode is not held
  // back a cycle by a stale flag and the falling change still interrupts.
  assign next_bus_off = !hard_reset && (tx_cnt > `CESR_BUS_OFF_LIMIT);
  assign next_rx_warn = cesr_at_warn({1'b0, rx_cnt});
  assign next_tx_warn = cesr_at_warn(tx_cnt);
  assign over_event = tx_fetch_fail || (frame_start && rx_store_busy) ||
                      (frame_start && id_cmp_busy) ||
                      (in_frame_head && (store_late || cmp_late));
  assign error_irq  = wake_flag || over_pulse;
  assign rx_buffer_count = cfg[4:0];

  // Receive bytes queue for RAM storage; a full queue stalls the source.
  cesr_fifo #(
    .WIDTH (`CESR_FIFO_WIDTH),
    .DEPTH (`CESR_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (rx_byte),
    .in_valid  (rx_byte_valid),
    .in_ready  (rx_byte_ready),
    .out_data  (store_data),
    .out_valid (store_valid),
    .out_ready (store_ready)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  // Error counters; saturating so the bus-off compare cannot wrap.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_cnt <= 9'h000;
      rx_cnt <= 8'h00;
    end else if (hard_reset || (bus_off_flag && idle_runs ==
                 `CESR_IDLE_RUNS)) begin
      tx_cnt <= 9'h000;
      rx_cnt <= 8'h00;
    end else begin
      if (tx_err_inc8 && tx_cnt < 9'h1F8) begin
        tx_cnt <= tx_cnt + 9'h008;
      end else if (tx_err_dec && tx_cnt != 9'h000 && !bus_off_flag) begin
        tx_cnt <= tx_cnt - 9'h001;
      end
      if (rx_err_inc8 && rx_cnt < 8'hF8) begin
        rx_cnt <= rx_cnt + 8'h08;
      end else if (rx_err_inc1 && rx_cnt != 8'hFF) begin
        rx_cnt <= rx_cnt + 8'h01;
      end else if (rx_err_dec && rx_cnt != 8'h00) begin
        rx_cnt <= rx_cnt - 8'h01;
      end
    end
  end

  // Recessive bit runs counted on the synchronised receive pin.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_bits <= 4'h0;
      idle_runs <= 8'h00;
    end else if (!bus_off_flag || hard_reset) begin
      idle_bits <= 4'h0;
      idle_runs <= 8'h00;
    end else if (bit_tick) begin
      if (!rx_sync) begin
        idle_bits <= 4'h0;
      end else if (idle_bits == `CESR_IDLE_BITS - 4'h1) begin
        idle_bits <= 4'h0;
        idle_runs <= idle_runs + 8'h01;
      end else begin
        idle_bits <= idle_bits + 4'h1;
      end
    end
  end

  // Status flags; warnings refreshed on frame end, bus-off on counter change.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_off_flag     <= 1'b0;
      rx_err_warn_flag <= 1'b0;
      tx_err_warn_flag <= 1'b0;
      status_irq       <= 1'b0;
    end else begin
      bus_off_flag     <= next_bus_off;
      if (frame_ok) begin
        rx_err_warn_flag <= next_rx_warn;
        tx_err_warn_flag <= next_tx_warn;
      end
      status_irq <= (bus_off_flag != next_bus_off) ||
                    (frame_ok && (rx_err_warn_flag != next_rx_warn)) ||
                    (frame_ok && (tx_err_warn_flag != next_tx_warn));
    end
  end

  // Grant is held back by bus-off and by any activity still running.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      config_mode_ack   <= 1'b0;
      init_set_by_reset <= 1'b0;
    end else begin
      init_set_by_reset <= hard_reset;
      if (hard_reset) begin
        config_mode_ack <= 1'b1;
      end else if (!init_request) begin
        config_mode_ack <= 1'b0;
      end else if (bus_off_flag) begin
        config_mode_ack <= 1'b0;
      end else if (!proto_busy && !internal_busy) begin
        config_mode_ack <= 1'b1;
      end
    end
  end

  // Set terms come last so they win over a software clear.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_flag <= 1'b0;
      wake_flag  <= 1'b0;
      over_flag  <= 1'b0;
      over_pulse <= 1'b0;
    end else begin
      over_pulse <= over_event;
      if (init_request) begin
        valid_flag <= 1'b0;
        wake_flag  <= 1'b0;
      end else if (wr_status) begin
        if (sfr_wdata[`CESR_BIT_VALID]) valid_flag <= 1'b0;
        if (sfr_wdata[`CESR_BIT_WAKE]) wake_flag <= 1'b0;
      end
      if (wr_status && sfr_wdata[`CESR_BIT_OVER]) begin
        over_flag <= 1'b0;
      end
      if (frame_ok) begin
        valid_flag <= 1'b1;
      end
      if ((sleep_mode && !rx_sync) || (sleep_request && proto_busy)) begin
        wake_flag <= 1'b1;
      end
      if (over_event) begin
        over_flag <= 1'b1;
      end
    end
  end

  // Late RAM work is judged over the first six bits of the next frame.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_bits      <= `CESR_SIX_BITS;
      store_late      <= 1'b0;
      cmp_late        <= 1'b0;
      rx_flags_block  <= 1'b0;
      msg_discard     <= 1'b0;
      tx_request_hold <= 1'b0;
    end else begin
      if (frame_start) begin
        frame_bits <= 3'h0;
        store_late <= rx_store_busy;
        cmp_late   <= id_cmp_busy;
      end else if (bit_tick && in_frame_head) begin
        frame_bits <= frame_bits + 3'h1;
      end
      rx_flags_block <= (frame_start && rx_store_busy) ||
                        (in_frame_head && store_late);
      msg_discard    <= (frame_start && id_cmp_busy) ||
                        (in_frame_head && cmp_late);
      if (tx_fetch_fail) begin
        tx_request_hold <= 1'b1;
      end else if (frame_ok) begin
        tx_request_hold <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= `CESR_RX_BUF_CFG_RST;
    end else if (sfr_wr && sfr_addr == `CESR_ADDR_RX_BUF_CFG &&
                 config_mode_ack) begin
      cfg <= {sfr_wdata[7:6], 1'b0,
              cesr_norm_count(sfr_wdata[4:0])};
    end
  end

  // Read data registered; unmapped addresses read zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `CESR_ADDR_ERR_STATUS: sfr_rdata <= {bus_off_flag, rx_err_warn_flag,
          tx_err_warn_flag, 1'b0, config_mode_ack, valid_flag, wake_flag,
          over_flag};
        `CESR_ADDR_RX_BUF_CFG: sfr_rdata <= cfg;
        `CESR_ADDR_TX_ERR_CNT: sfr_rdata <= tx_cnt[7:0];
        `CESR_ADDR_RX_ERR_CNT: sfr_rdata <= rx_cnt;
        default:               sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> hdl/cesr_consts.vh
// Constants for the CAN error status and receive count block.
// How it works
// - Writing zero leaves valid, wake, overrun flags; writing one clears them.
// - A set event in the same cycle beats a software clear.
// - Bus-off flag reads one while transmit error count exceeds 255.
// - Bus-off clears after 128 runs of 11 recessive bits, or hard reset.
// - Every change of the bus-off flag raises an interrupt pulse.
// - Receive warning is one when receive count is 96 or more.
// - Transmit warning is one when transmit count is 96 or more.
// - Config acknowledge follows init only once bus and internals are idle.
// - While bus-off, init is ignored and acknowledge stays zero.
// - Valid flag sets at end of every error-free received frame.
// - Valid flag clears on write of one or when init is set.
// - Wake flag sets on bus activity in sleep or refused sleep request.
// - Error interrupt stays high while wake flag is set.
// - Wake flag clears on write of one or when init is set.
// - RAM access shortfall sets overrun flag and error interrupt together.
// - Failed transmit fetch keeps the request set for a retransmit.
// - Late receive store in next frame's first six bits blocks flags.
// - Late identifier compare in next frame's first six bits drops message.
// - Transmit error count reads as an 8-bit read-only register, reset 0.
// - Receive error count reads as an 8-bit read-only register, reset 0.
// - Buffer config readable always, writable only in configuration mode.
// - Count field 1..16, though reset and a write of 0 leave it 0; top bit with nonzero low part becomes 16.
// - Init bit is only a request; it acts once granted.
// - Hard reset while bus-off enters configuration with init and ack set.
`ifndef CESR_CONSTS_VH
`define CESR_CONSTS_VH
`define CESR_ADDR_ERR_STATUS 16'hFFB4
`define CESR_ADDR_RX_BUF_CFG 16'hFFB7
`define CESR_ADDR_TX_ERR_CNT 16'hFFB5
`define CESR_ADDR_RX_ERR_CNT 16'hFFB6
`define CESR_ERR_STATUS_RST  8'h00
`define CESR_RX_BUF_CFG_RST  8'hC0
`define CESR_BIT_BUS_OFF     7
`define CESR_BIT_RX_WARN     6
`define CESR_BIT_TX_WARN     5
`define CESR_BIT_CFG_ACK     3
`define CESR_BIT_VALID       2
`define CESR_BIT_WAKE        1
`define CESR_BIT_OVER        0
`define CESR_BIT_HARD_RESET  5
`define CESR_BUS_OFF_LIMIT   9'h0FF
`define CESR_WARN_LEVEL      9'h060
`define CESR_IDLE_BITS       4'hB
`define CESR_IDLE_RUNS       8'h80
`define CESR_SIX_BITS        3'h6
`define CESR_COUNT_MAX       5'h10
`define CESR_FIFO_WIDTH      8
`define CESR_FIFO_DEPTH      8
`endif

// >>> verification/cesr_bus_model.sv
// Far side model: bus level, bit timing and the store sink.
`timescale 1ns/1ps
`default_nettype none
module cesr_bus_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       idle,
  input  wire logic       stall,
  input  wire logic       store_valid,
  input  wire logic [7:0] store_data,
  output var  logic       rx_pin,
  output var  logic       bit_tick,
  output var  logic       store_ready
);
  logic [7:0] got_q[$];
  // A busy bus toggles every clock so the receiver always sees dominant
  // edges, whatever the seed.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_pin <= 1'b1;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= ~bit_tick;
      rx_pin <= idle | bit_tick;
    end
  end
  always @(posedge clk) begin
    if (store_valid && store_ready) got_q.push_back(store_data);
  end
  always_comb store_ready = ~stall;
endmodule
`default_nettype wire

// >>> verification/cesr_chk.sv
// Assertion checker for the CAN error status block.
`timescale 1ns/1ps
`default_nettype none
module cesr_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sleep_request,
  input wire logic       proto_busy,
  input wire logic       frame_ok,
  input wire logic       frame_start,
  input wire logic       tx_fetch_fail,
  input wire logic       rx_store_busy,
  input wire logic       id_cmp_busy,
  input wire logic       tx_request_hold,
  input wire logic       rx_flags_block,
  input wire logic       msg_discard,
  input wire logic       error_irq,
  input wire logic       store_valid,
  input wire logic       store_ready,
  input wire logic [7:0] store_data,
  input wire logic [4:0] rx_buffer_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_refused; sleep_request && proto_busy; endsequence
  sequence s_held; ##[1:3] error_irq [*4]; endsequence
  property p_wake; s_refused |-> s_held; endproperty
  property p_cnt; rx_buffer_count[4] |-> rx_buffer_count[3:0] == 4'h0;
  endproperty
  property p_hold; tx_fetch_fail && !frame_ok |=> tx_request_hold; endproperty
  property p_ovr; tx_fetch_fail |-> ##[0:2] error_irq; endproperty
  property p_blk; frame_start && rx_store_busy |=> rx_flags_block; endproperty
  property p_disc; frame_start && id_cmp_busy |=> msg_discard; endproperty
  // A stalled sink must see the same word until it takes it.
  property p_fifo;
    store_valid && !store_ready |=> store_valid && $stable(store_data);
  endproperty
  property p_rd; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_wake: assert property (p_wake)
    else $error("error irq not held");
  a_cnt: assert property (p_cnt)
    else $error("count above 16");
  a_hold: assert property (p_hold)
    else $error("tx request not held");
  a_ovr: assert property (p_ovr)
    else $error("no overrun irq");
  a_blk: assert property (p_blk)
    else $error("rx flags not blocked");
  a_disc: assert property (p_disc)
    else $error("message not discarded");
  a_fifo: assert property (p_fifo)
    else $error("store word dropped");
  a_rd: assert property (p_rd)
    else $error("read data moved");
endmodule
bind cesr_block cesr_chk u_cesr_chk (.clk(clk), .rst(rst), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .sleep_request(sleep_request),
  .proto_busy(proto_busy), .frame_ok(frame_ok), .frame_start(frame_start),
  .tx_fetch_fail(tx_fetch_fail), .rx_store_busy(rx_store_busy),
  .id_cmp_busy(id_cmp_busy), .tx_request_hold(tx_request_hold),
  .rx_flags_block(rx_flags_block), .msg_discard(msg_discard),
  .error_irq(error_irq), .store_valid(store_valid),
  .store_ready(store_ready), .store_data(store_data),
  .rx_buffer_count(rx_buffer_count));
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the CAN error status block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, idle = 1, stall = 0;
  logic [15:0] sfr_addr = 0;
  logic [7:0]  sfr_wdata = 0, rx_byte = 0, sfr_rdata, store_data, d, v;
  logic        init_request = 0, sleep_request = 0, proto_busy = 0;
  logic        sleep_mode = 0, frame_ok = 0, frame_start = 0;
  logic        rx_err_inc8 = 0, tx_err_inc8 = 0, tx_fetch_fail = 0;
  logic        rx_store_busy = 0, id_cmp_busy = 0, rx_byte_valid = 0;
  logic        rx_pin, bit_tick, store_ready, rx_byte_ready, store_valid;
  logic        error_irq, status_irq, init_set_by_reset;
  logic [4:0]  rx_buffer_count;
  logic [7:0]  exp_q[$];
  int          n_errors = 0, samples_checked = 0, i, n_irq = 0;
  always #20 clk = ~clk;
  // Counted mid-cycle so each one-cycle pulse is seen exactly once.
  always @(negedge clk)
    if (status_irq === 1'b1) n_irq++;
  cesr_block u_cesr_block (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .init_request(init_request),
    .sleep_request(sleep_request),
    .init_set_by_reset(init_set_by_reset), .rx_pin(rx_pin),
    .proto_busy(proto_busy), .internal_busy(1'b0), .sleep_mode(sleep_mode),
    .bit_tick(bit_tick), .frame_ok(frame_ok), .frame_start(frame_start),
    .rx_err_inc1(1'b0), .rx_err_inc8(rx_err_inc8), .rx_err_dec(1'b0),
    .tx_err_inc8(tx_err_inc8), .tx_err_dec(1'b0),
    .tx_fetch_fail(tx_fetch_fail), .rx_store_busy(rx_store_busy),
    .id_cmp_busy(id_cmp_busy), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
    .store_data(store_data), .store_valid(store_valid),
    .store_ready(store_ready), .rx_flags_block(), .msg_discard(),
    .tx_request_hold(), .status_irq(status_irq), .error_irq(error_irq),
    .rx_buffer_count(rx_buffer_count));
  cesr_bus_model u_cesr_bus_model (.clk(clk), .rst(rst), .idle(idle),
    .stall(stall), .store_valid(store_valid), .store_data(store_data),
    .rx_pin(rx_pin), .bit_tick(bit_tick), .store_ready(store_ready));
  function automatic logic [4:0] ex(input logic [7:0] w);
    return w[4] ? 5'h10 : w[4:0];
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] w);
    sfr_addr = a;
    sfr_wdata = w;
    sfr_wr = 1;
    tick();
    sfr_wr = 0;
  endtask
  task automatic rd(input logic [15:0] a);
    sfr_addr = a;
    sfr_rd = 1;
    tick();
    d = sfr_rdata;
    sfr_rd = 0;
    tick();
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #480000;
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h6E09DF2B));
    tick(2);
    rst = 0;
    rd(16'hFFB4);
    `CHK("status", 8'h00, d)
    rd(16'hFFB5);
    `CHK("tx count", 8'h00, d)
    rd(16'hFFB6);
    `CHK("rx count", 8'h00, d)
    rd(16'hFFB7);
    `CHK("cfg", 8'hC0, d)
    wr(16'hFFB7, 8'h03);
    tick();
    `CHK("cfg locked", 5'h00, rx_buffer_count)
    proto_busy = 1;
    init_request = 1;
    tick(3);
    rd(16'hFFB4);
    `CHK("ack busy", 1'b0, d[3])
    proto_busy = 0;
    tick(2);
    rd(16'hFFB4);
    `CHK("ack", 1'b1, d[3])
    for (i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h1F : (i == 1) ? 8'h10 : 8'($urandom);
      v[5] = 0;
      if (v[4:0] == 0) v[0] = 1;
      wr(16'hFFB7, v);
      tick();
      `CHK("count", ex(v), rx_buffer_count)
    end
    init_request = 0;
    $display("test config done");
    frame_ok = 1;
    wr(16'hFFB4, 8'h00);
    frame_ok = 0;
    rd(16'hFFB4);
    `CHK("valid w0", 1'b1, d[2])
    frame_ok = 1;
    wr(16'hFFB4, 8'h04);
    frame_ok = 0;
    rd(16'hFFB4);
    `CHK("valid set wins", 1'b1, d[2])
    wr(16'hFFB4, 8'h04);
    rd(16'hFFB4);
    `CHK("valid w1", 1'b0, d[2])
    frame_ok = 1;
    tick();
    frame_ok = 0;
    init_request = 1;
    tick(2);
    rd(16'hFFB4);
    `CHK("valid init", 1'b0, d[2])
    init_request = 0;
    $display("test valid done");
    for (i = 0; i < 2; i++) begin
      sleep_mode = 1'(i);
      idle = 0;
      proto_busy = !i;
      sleep_request = !i;
      tick();
      sleep_request = 0;
      proto_busy = 0;
      tick(8);
      sleep_mode = 0;
      idle = 1;
      rd(16'hFFB4);
      `CHK("wake", 1'b1, d[1])
      `CHK("err irq", 1'b1, error_irq)
      wr(16'hFFB4, 8'h02);
      tick();
      `CHK("err irq off", 1'b0, error_irq)
    end
    tx_fetch_fail = 1;
    tick();
    tx_fetch_fail = 0;
    rd(16'hFFB4);
    `CHK("over", 1'b1, d[0])
    wr(16'hFFB4, 8'h01);
    rd(16'hFFB4);
    `CHK("over clear", 1'b0, d[0])
    {frame_start, rx_store_busy, id_cmp_busy} = 3'h7;
    tick();
    {frame_start, rx_store_busy, id_cmp_busy, frame_ok} = 4'h1;
    tick();
    frame_ok = 0;
    $display("test wake done");
    for (i = 0; i < 32; i++) begin
      tx_err_inc8 = 1;
      rx_err_inc8 = (i < 12);
      tick();
      {tx_err_inc8, rx_err_inc8} = 2'h0;
      tick();
      if (i == 11) begin
        frame_ok = 1;
        tick();
        frame_ok = 0;
        tick();
        rd(16'hFFB4);
        `CHK("warnings", 2'h3, d[6:5])
        rd(16'hFFB5);
        `CHK("tx count", 8'h60, d)
        rd(16'hFFB6);
        `CHK("rx count", 8'h60, d)
      end
      if (i == 30) rd(16'hFFB4);
      if (i == 30) `CHK("below limit", 1'b0, d[7])
    end
    tick();
    rd(16'hFFB4);
    `CHK("bus off", 1'b1, d[7])
    init_request = 1;
    tick(3);
    rd(16'hFFB4);
    `CHK("ack in bus off", 1'b0, d[3])
    i = 0;
    while (d[7] && i < 4000) begin
      rd(16'hFFB4);
      i++;
    end
    `CHK("recovery time", 1'b1, i > 1395 && i < 1415)
    `CHK("bus off left", 1'b0, d[7])
    tick(2);
    rd(16'hFFB4);
    `CHK("ack after", 1'b1, d[3])
    `CHK("status irqs", 3, n_irq)
    tx_err_inc8 = 1;
    tick(32);
    tx_err_inc8 = 0;
    tick(2);
    wr(16'hFFB7, 8'h20);
    `CHK("reset pulse", 1'b1, init_set_by_reset)
    tick();
    rd(16'hFFB4);
    `CHK("hard reset", 2'h1, {d[7], d[3]})
    rd(16'hFFB5);
    `CHK("count cleared", 8'h00, d)
    `CHK("status irqs", 5, n_irq)
    init_request = 0;
    $display("test bus off done");
    stall = 1;
    i = 0;
    while (rx_byte_ready && i < 20) begin
      rx_byte = 8'($urandom);
      rx_byte_valid = 1;
      exp_q.push_back(rx_byte);
      tick();
      i++;
    end
    rx_byte_valid = 0;
    `CHK("fifo fill", 1'b1, i >= 8)
    stall = 0;
    tick(20);
    foreach (exp_q[k]) `CHK("fifo data", exp_q[k], u_cesr_bus_model.got_q[k])
    `CHK("fifo size", exp_q.size(), u_cesr_bus_model.got_q.size())
    `CHK("fifo empty", 1'b0, store_valid)
    $display("test fifo done");
    end_sim();
  end
endmodule
`default_nettype wire
